// ===== tsp_pkg.sv
// shared constants, types and helpers for the touch controller serial port
// assumes a single 250 MHz core clock and a host-driven serial clock of about 12.5 MHz
package tsp_pkg;

   // register addresses
   localparam logic [6:0] FIFO_ADDR           = 7'h50;
   localparam logic [6:0] X_RESULT_HIGH_ADDR  = 7'h52;
   localparam logic [6:0] AUX_RESULT_LOW_ADDR = 7'h5b;
   localparam logic [6:0] CONV_CMD_MIN_ADDR   = 7'h70;

   // first byte layout: address in [7:1], mode in [0]
   localparam int         CMD_ADDR_MSB = 7;
   localparam int         CMD_ADDR_LSB = 1;
   localparam int         CMD_MODE_BIT = 0;
   localparam logic       MODE_READ    = 1'b1;

   // fifo tag fields in the low byte of each result pair
   localparam logic [1:0] EVT_INITIAL  = 2'h0;
   localparam logic [1:0] EVT_MIDPRESS = 2'h1;
   localparam logic [1:0] EVT_RELEASE  = 2'h2;
   localparam logic [1:0] EVT_EOF      = 2'h3;
   localparam logic [1:0] MEAS_X       = 2'h0;
   localparam logic [1:0] MEAS_Y       = 2'h1;
   localparam logic [1:0] MEAS_Z1      = 2'h2;
   localparam logic [1:0] MEAS_Z2      = 2'h3;

   // serial framing counts
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam logic [2:0] BIT_ADDR_LAST = 3'h6;
   localparam logic [1:0] MARK_EDGES    = 2'h2;
   localparam logic [1:0] FIFO_BYTE_0   = 2'h0;

   // reset values
   localparam logic [6:0] RD_ADDR_RST = 7'h00;
   localparam logic [7:0] SHIFT_RST   = 8'h00;

   typedef enum logic [1:0] {
      PS_IDLE,
      PS_CMD,
      PS_WRITE,
      PS_READ
   } tsp_phase_t;

   // result registers step forward up to the aux low byte, all others repeat
   function automatic logic [6:0] tsp_next_addr(input logic [6:0] addr);
      if (addr >= X_RESULT_HIGH_ADDR && addr < AUX_RESULT_LOW_ADDR) begin
         return 7'(addr + 7'h01);
      end
      return addr;
   endfunction

   // block returned when no logged entry is waiting
   function automatic logic [31:0] tsp_eof_block();
      return {8'h00, 4'h0, MEAS_X, EVT_EOF, 8'h00, 4'h0, MEAS_Y, EVT_EOF};
   endfunction

   function automatic logic [7:0] tsp_block_byte(input logic [31:0] blk, input logic [1:0] idx);
      logic [7:0] b;
      b = 8'h00;
      unique case (idx)
         2'h0: b = blk[31:24];
         2'h1: b = blk[23:16];
         2'h2: b = blk[15:8];
         2'h3: b = blk[7:0];
      endcase
      return b;
   endfunction

endpackage

// ===== tsp_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes inputs change far slower than the core clock
`timescale 1ns/1ps
module tsp_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         ref_clk,   // core clock
   input  wire logic         sys_rst,   // synchronous reset
   input  wire logic [W-1:0] async_in,  // raw pins
   output logic      [W-1:0] level      // filtered level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } tsp_sync_t;

   tsp_sync_t s;
   tsp_sync_t next_s;

   // a bit follows once the second and third stage agree
   always_comb begin
      next_s     = s;
      next_s.s1  = async_in;
      next_s.s2  = s.s1;
      next_s.s3  = s.s2;
      next_s.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 ^ s.s3));
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         s <= next_s;
      end
   end

   assign level = s.lvl;
endmodule

// ===== tsp_skid.sv
// two-entry buffer with registered outputs and valid/ready on both sides
// assumes the drain side holds ready as a level from its own logic
`timescale 1ns/1ps
module tsp_skid #(
   parameter int W = 15
) (
   input  wire logic         ref_clk,    // core clock
   input  wire logic         sys_rst,    // synchronous reset
   input  wire logic         in_valid,   // word offered
   input  wire logic [W-1:0] in_data,    // word
   output logic              in_ready,   // room for a word
   output logic              out_valid,  // word waiting
   output logic      [W-1:0] out_data,   // waiting word
   input  wire logic         out_ready   // drain takes word
);
   typedef struct packed {
      logic         out_v;
      logic [W-1:0] out_d;
      logic         skid_v;
      logic [W-1:0] skid_d;
      logic         rdy;
   } tsp_skid_t;

   tsp_skid_t s;
   tsp_skid_t next_s;

   always_comb begin
      next_s = s;
      if (s.out_v && out_ready) begin
         next_s.out_v  = s.skid_v;
         next_s.out_d  = s.skid_d;
         next_s.skid_v = 1'b0;
      end
      if (in_valid && s.rdy) begin
         if (!next_s.out_v) begin
            next_s.out_v = 1'b1;
            next_s.out_d = in_data;
         end else begin
            next_s.skid_v = 1'b1;
            next_s.skid_d = in_data;
         end
      end
      next_s.rdy = !next_s.skid_v;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s     <= '0;
         s.rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign in_ready  = s.rdy;
   assign out_valid = s.out_v;
   assign out_data  = s.out_d;
endmodule

// ===== tsp_spi_port.sv
// serial register access port of a resistive touch controller
// assumes: register file answers reg_rd_data within two core cycles of reg_rd_addr,
// fifo head stays put until fifo_mark, serial clock idles low and is far slower than ref_clk
//
// Overview of operation
// - select high ignores the serial port and keeps data output released.
// - a write is address byte with write mode, then one data byte.
// - the data output is never driven during a write frame.
// - repeated address and data pairs in one frame each write a register.
// - a read is address byte with read mode, then the register byte out.
// - output driven from the eighth rising edge until select rises.
// - after the sixteenth edge further register bytes keep shifting out.
// - optional bus holder keeps the last line level without fighting drivers.
// - multi-byte reads step the register or repeat the last valid one.
// - stepping covers result registers only and stops at aux low byte.
// - the fifo address never steps; further bytes deliver further blocks.
// - a fifo block is marked read once its first byte gets two bit cycles.
// - fifo block of four bytes shifts out on rising edges 8 to 39.
// - edge 40 shows next block unmarked; edge 42 marks it.
// - a conversion command stands alone and is dropped while busy.
// - event tags are 00 initial, 01 midpress, 10 release.
// - event tag 11 marks an empty fifo read with invalid data.
// - measurement tags are 00 X, 01 Y, 10 Z1, 11 Z2.
`timescale 1ns/1ps
module tsp_spi_port
   import tsp_pkg::*;
(
   input  wire logic        ref_clk,         // core clock, 250 MHz
   input  wire logic        sys_rst,         // synchronous reset, active high
   input  wire logic        select_n,        // chip select pin, active low
   input  wire logic        serial_clock_in, // serial clock pin
   input  wire logic        din,             // serial data in pin
   input  wire logic        dout_line,       // sensed level of the output wire
   input  wire logic        holder_enable,   // bus holder option pin
   output logic             dout,            // serial data out
   output logic             dout_oe,         // data out enable
   output logic             holder_level,    // level the holder keeps
   output logic             holder_drive,    // holder active, weak drive
   output logic      [6:0]  reg_rd_addr,     // register read address
   input  wire logic [7:0]  reg_rd_data,     // register read data
   output logic             wr_valid,        // register write waiting
   output logic      [6:0]  wr_addr,         // register write address
   output logic      [7:0]  wr_data,         // register write data
   input  wire logic        wr_ready,        // register file takes write
   output logic             wr_drop,         // sticky: write lost, buffer full
   input  wire logic        wr_drop_clear,   // clears wr_drop
   input  wire logic [31:0] fifo_block,      // fifo head block
   input  wire logic        fifo_avail,      // fifo head holds an entry
   output logic             fifo_mark,       // pulse: head block marked read
   input  wire logic        conv_busy,       // earlier command still running
   output logic             conv_start,      // pulse: conversion accepted
   output logic      [6:0]  conv_cmd,        // accepted conversion code
   output logic             frame_active     // select low frame in progress
);
   localparam int WR_W = 15;

   typedef struct packed {
      tsp_phase_t  phase;
      logic        sclk_prev;
      logic [2:0]  bit_idx;
      logic [1:0]  bytes;
      logic [7:0]  shift_in;
      logic [6:0]  addr;
      logic        want_data;
      logic [7:0]  shift_out;
      logic [1:0]  fifo_byte;
      logic [31:0] block;
      logic        mark_pend;
      logic [1:0]  mark_cnt;
      logic        dout;
      logic        dout_oe;
      logic        holder_level;
      logic        holder_drive;
      logic [6:0]  rd_addr;
      logic        conv_start;
      logic [6:0]  conv_cmd;
      logic        fifo_mark;
      logic        push_valid;
      logic [6:0]  push_addr;
      logic [7:0]  push_data;
      logic        wr_drop;
      logic        frame_active;
   } tsp_port_t;

   tsp_port_t s;
   tsp_port_t next_s;

   logic [4:0] pin_level;
   logic       cs_n_f;
   logic       sclk_f;
   logic       din_f;
   logic       line_f;
   logic       hold_en_f;
   logic       buf_in_ready;

   tsp_sync #(
      .W       (5),
      .RST_VAL (5'h01)
   ) u_sync (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .async_in ({holder_enable, dout_line, din, serial_clock_in, select_n}),
      .level    (pin_level)
   );

   assign cs_n_f    = pin_level[0];
   assign sclk_f    = pin_level[1];
   assign din_f     = pin_level[2];
   assign line_f    = pin_level[3];
   assign hold_en_f = pin_level[4];

   tsp_skid #(
      .W (WR_W)
   ) u_wr_buf (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .in_valid  (s.push_valid),
      .in_data   ({s.push_addr, s.push_data}),
      .in_ready  (buf_in_ready),
      .out_valid (wr_valid),
      .out_data  ({wr_addr, wr_data}),
      .out_ready (wr_ready)
   );

   always_comb begin
      logic       rise;
      logic [7:0] nshift;
      logic       byte_done;
      logic       load;
      logic [6:0] load_addr;
      logic [31:0] blk;
      rise      = sclk_f & ~s.sclk_prev;
      nshift    = {s.shift_in[6:0], din_f};
      byte_done = (s.bit_idx == BIT_LAST);
      load      = 1'b0;
      load_addr = s.addr;
      blk       = s.block;

      next_s            = s;
      next_s.sclk_prev  = sclk_f;
      next_s.conv_start = 1'b0;
      next_s.fifo_mark  = 1'b0;
      next_s.push_valid = 1'b0;

      if (cs_n_f) begin
         // lone first byte in a conversion range is a conversion request
         if (s.phase != PS_IDLE && s.bytes == 2'h1 && s.bit_idx == 3'h0 &&
             s.addr >= CONV_CMD_MIN_ADDR && !conv_busy) begin
            next_s.conv_start = 1'b1;
            next_s.conv_cmd   = s.addr;
         end
         next_s.phase     = PS_IDLE;
         next_s.bit_idx   = 3'h0;
         next_s.bytes     = 2'h0;
         next_s.want_data = 1'b0;
         next_s.mark_pend = 1'b0;
         next_s.dout_oe   = 1'b0;
      end else begin
         if (s.phase == PS_IDLE) begin
            next_s.phase = PS_CMD;
         end
         if (rise) begin
            // msb first, sampled on rising serial clock
            next_s.shift_in = nshift;
            next_s.bit_idx  = s.bit_idx + 3'h1;
            if (byte_done && s.bytes != 2'h3) begin
               next_s.bytes = s.bytes + 2'h1;
            end
            if (s.mark_pend) begin
               next_s.mark_cnt = s.mark_cnt + 2'h1;
               if (next_s.mark_cnt == MARK_EDGES) begin
                  next_s.fifo_mark = 1'b1;
                  next_s.mark_pend = 1'b0;
               end
            end
            unique case (s.phase)
               PS_IDLE, PS_CMD: begin
                  // address is complete one edge early, start the fetch
                  if (s.bit_idx == BIT_ADDR_LAST) begin
                     next_s.rd_addr = nshift[6:0];
                  end
                  if (byte_done) begin
                     next_s.addr = nshift[CMD_ADDR_MSB:CMD_ADDR_LSB];
                     if (nshift[CMD_MODE_BIT] == MODE_READ &&
                         nshift[CMD_ADDR_MSB:CMD_ADDR_LSB] < CONV_CMD_MIN_ADDR) begin
                        next_s.phase   = PS_READ;
                        next_s.dout_oe = 1'b1;
                        load           = 1'b1;
                        load_addr      = nshift[CMD_ADDR_MSB:CMD_ADDR_LSB];
                        next_s.fifo_byte = FIFO_BYTE_0;
                     end else begin
                        next_s.phase     = PS_WRITE;
                        next_s.want_data = 1'b1;
                     end
                  end
               end
               PS_WRITE: begin
                  if (byte_done) begin
                     if (s.want_data) begin
                        next_s.push_valid = 1'b1;
                        next_s.push_addr  = s.addr;
                        next_s.push_data  = nshift;
                        next_s.want_data  = 1'b0;
                     end else begin
                        next_s.addr      = nshift[CMD_ADDR_MSB:CMD_ADDR_LSB];
                        next_s.want_data = 1'b1;
                     end
                  end
               end
               PS_READ: begin
                  if (byte_done) begin
                     load = 1'b1;
                  end else begin
                     next_s.shift_out = {s.shift_out[6:0], 1'b0};
                  end
               end
            endcase
            if (load) begin
               if (load_addr == FIFO_ADDR) begin
                  // fifo address stays, each fourth byte opens a new block
                  if (s.fifo_byte == FIFO_BYTE_0 || s.phase != PS_READ) begin
                     blk = fifo_avail ? fifo_block : tsp_eof_block();
                     next_s.block     = blk;
                     next_s.mark_pend = fifo_avail;
                     next_s.mark_cnt  = 2'h0;
                     next_s.shift_out = tsp_block_byte(blk, FIFO_BYTE_0);
                     next_s.fifo_byte = 2'h1;
                  end else begin
                     next_s.shift_out = tsp_block_byte(s.block, s.fifo_byte);
                     next_s.fifo_byte = s.fifo_byte + 2'h1;
                  end
               end else begin
                  next_s.shift_out = reg_rd_data;
                  next_s.addr      = tsp_next_addr(load_addr);
                  next_s.rd_addr   = tsp_next_addr(load_addr);
               end
            end
         end
      end

      next_s.frame_active = ~cs_n_f;
      next_s.dout         = next_s.dout_oe & next_s.shift_out[7];
      next_s.holder_level = line_f;
      next_s.holder_drive = hold_en_f & ~next_s.dout_oe;
      // a lost write sets the flag even if cleared in the same cycle
      if (wr_drop_clear) begin
         next_s.wr_drop = 1'b0;
      end
      if (s.push_valid && !buf_in_ready) begin
         next_s.wr_drop = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s           <= '0;
         s.phase     <= PS_IDLE;
         s.rd_addr   <= RD_ADDR_RST;
         s.shift_out <= SHIFT_RST;
      end else begin
         s <= next_s;
      end
   end

   assign dout         = s.dout;
   assign dout_oe      = s.dout_oe;
   assign holder_level = s.holder_level;
   assign holder_drive = s.holder_drive;
   assign reg_rd_addr  = s.rd_addr;
   assign wr_drop      = s.wr_drop;
   assign fifo_mark    = s.fifo_mark;
   assign conv_start   = s.conv_start;
   assign conv_cmd     = s.conv_cmd;
   assign frame_active = s.frame_active;
endmodule

// ===== tsp_spi_port_props.sv
// checker for the touch controller serial port
// assumes select_n is a raw pin and wr_drop_clear acts on the next edge
`timescale 1ns/1ps
module tsp_spi_port_props (
   input wire logic       ref_clk,       // core clock
   input wire logic       sys_rst,       // synchronous reset
   input wire logic       select_n,      // chip select pin
   input wire logic       dout,          // data out
   input wire logic       dout_oe,       // data out enable
   input wire logic       holder_drive,  // holder active
   input wire logic       wr_valid,      // write waiting
   input wire logic [6:0] wr_addr,       // write address
   input wire logic [7:0] wr_data,       // write data
   input wire logic       wr_ready,      // write taken
   input wire logic       wr_drop,       // write lost
   input wire logic       wr_drop_clear, // clears loss flag
   input wire logic       fifo_mark,     // block marked
   input wire logic       conv_start,    // conversion accepted
   input wire logic       frame_active   // frame in progress
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   logic [3:0] hi_cnt;
   logic [3:0] lo_cnt;
   // consecutive cycles of select high and low, saturating
   always_ff @(posedge ref_clk) begin
      hi_cnt <= (sys_rst || !select_n) ? 4'h0 : ((hi_cnt == 4'hf) ? hi_cnt : hi_cnt + 4'h1);
      lo_cnt <= (sys_rst || select_n) ? 4'h0 : ((lo_cnt == 4'hf) ? lo_cnt : lo_cnt + 4'h1);
   end
   property p_idle_released;
      hi_cnt >= 4'h8 |-> !dout_oe && !frame_active;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("output driven while idle");
   property p_low_when_off;
      !dout_oe |-> !dout;
   endproperty
   a_low_when_off: assert property (p_low_when_off) else $error("dout high while released");
   property p_no_fight;
      dout_oe |-> !holder_drive;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("holder fights driver");
   property p_oe_in_frame;
      $rose(dout_oe) |-> frame_active;
   endproperty
   a_oe_in_frame: assert property (p_oe_in_frame) else $error("drive outside frame");
   property p_oe_stands;
      dout_oe && lo_cnt >= 4'h8 |=> dout_oe;
   endproperty
   a_oe_stands: assert property (p_oe_stands) else $error("drive dropped in frame");
   property p_mark_pulse;
      fifo_mark |-> frame_active ##1 !fifo_mark;
   endproperty
   a_mark_pulse: assert property (p_mark_pulse) else $error("bad mark pulse");
   property p_conv_alone;
      conv_start |-> !frame_active ##1 !conv_start;
   endproperty
   a_conv_alone: assert property (p_conv_alone) else $error("bad conversion pulse");
   property p_wr_hold;
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write changed while stalled");
   property p_drop_sticky;
      wr_drop && !wr_drop_clear |=> wr_drop;
   endproperty
   a_drop_sticky: assert property (p_drop_sticky) else $error("loss flag fell alone");
endmodule
bind tsp_spi_port tsp_spi_port_props u_props (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .select_n(select_n), .dout(dout),
   .dout_oe(dout_oe), .holder_drive(holder_drive), .wr_valid(wr_valid),
   .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .wr_drop(wr_drop),
   .wr_drop_clear(wr_drop_clear), .fifo_mark(fifo_mark), .conv_start(conv_start),
   .frame_active(frame_active)
);

// ===== tsp_host_model.sv
// serial master model: frames of any edge count, 80 ns serial clock
// assumes wire_in is the resolved level of the data out wire
`timescale 1ns/1ps
module tsp_host_model (
   input  wire logic ref_clk,  // core clock
   input  wire logic wire_in,  // resolved data out wire
   output logic      select_n, // chip select
   output logic      sclk,     // serial clock, low outside frames
   output logic      din       // serial data
);
   initial begin
      select_n = 1'b1;
      sclk     = 1'b0;
      din      = 1'b0;
   end
   task automatic half();
      repeat (10) @(posedge ref_clk);
      #1;
   endtask
   // one frame: write pairs, one read command or one lone conversion command
   task automatic frame(input logic [7:0] tx[$], input int edges, output logic [7:0] rx[$]);
      logic [7:0] sh;
      int         i;
      rx = {};
      sh = 8'h00;
      select_n = 1'b0;
      half();
      for (i = 0; i < edges; i++) begin
         if (i / 8 < tx.size()) begin
            din = tx[i / 8][7 - i % 8];
         end else begin
            din = ~din;
         end
         half();
         sclk = 1'b1;
         half();
         if (i >= 7) begin
            sh = {sh[6:0], wire_in};
            if (i % 8 == 6) begin
               rx.push_back(sh);
            end
         end
         sclk = 1'b0;
      end
      half();
      select_n = 1'b1;
      half();
   endtask
endmodule

// ===== tsp_spi_port_tb_top.sv
// self-checking bench for the serial port with register file and fifo models
// assumes the checker is bound through its own file
`timescale 1ns/1ps
module tsp_spi_port_tb_top;
   import tsp_pkg::*;
   logic        ref_clk, sys_rst, select_n, sclk, din, dout_wire;
   logic        holder_enable, dout, dout_oe, holder_level, holder_drive;
   logic [6:0]  reg_rd_addr, wr_addr, conv_cmd;
   logic [7:0]  reg_rd_data, wr_data;
   logic        wr_valid, wr_ready, wr_drop, wr_drop_clear, fifo_avail, fifo_mark;
   logic        conv_busy, conv_start, frame_active, rdy_free, in_wr;
   logic        last_wire = 1'b0;
   logic [31:0] fifo_block, seed;
   logic [7:0]  regs [128];
   logic [31:0] fq [$];
   logic [14:0] wseen [$];
   logic [14:0] wexp [$];
   logic [7:0]  tx [$];
   logic [7:0]  rx [$];
   int          fail_count, n_tests, marks, convs, oe_wr;
   // released wire shows a changing level
   assign dout_wire   = dout_oe ? dout : (holder_drive ? holder_level : ~last_wire);
   assign reg_rd_data = regs[reg_rd_addr];
   tsp_host_model host (.ref_clk(ref_clk), .wire_in(dout_wire), .select_n(select_n),
      .sclk(sclk), .din(din));
   tsp_spi_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .select_n(select_n),
      .serial_clock_in(sclk), .din(din), .dout_line(dout_wire),
      .holder_enable(holder_enable), .dout(dout), .dout_oe(dout_oe),
      .holder_level(holder_level), .holder_drive(holder_drive), .reg_rd_addr(reg_rd_addr),
      .reg_rd_data(reg_rd_data), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_ready(wr_ready), .wr_drop(wr_drop), .wr_drop_clear(wr_drop_clear),
      .fifo_block(fifo_block), .fifo_avail(fifo_avail), .fifo_mark(fifo_mark),
      .conv_busy(conv_busy), .conv_start(conv_start), .conv_cmd(conv_cmd),
      .frame_active(frame_active));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #100_000;
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   // register file and fifo side, sampled at the edge and driven just after
   always begin : drv
      logic [31:0] r;
      @(posedge ref_clk);
      if (wr_valid && wr_ready) wseen.push_back({wr_addr, wr_data});
      if (fifo_mark) marks++;
      if (fifo_mark && fq.size() > 0) void'(fq.pop_front());
      if (conv_start) convs++;
      if (in_wr && dout_oe) oe_wr++;
      last_wire <= dout_wire;
      #1;
      r = rnd();
      wr_ready = rdy_free & r[3];
      fifo_avail = fq.size() > 0;
      fifo_block = fifo_avail ? fq[0] : r;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic do_read(input logic [6:0] a, input int n);
      int k;
      holder_enable = ~holder_enable;
      tx = {};
      tx.push_back({a, MODE_READ});
      host.frame(tx, 8 + 8 * n, rx);
      chk(rx.size(), n);
      for (k = 0; k < n; k++) begin
         chk(rx[k], regs[a]);
         if (a >= X_RESULT_HIGH_ADDR && a < AUX_RESULT_LOW_ADDR) a++;
      end
      // with the holder on, released wire keeps bit 7 of the byte loaded at the last edge
      chk(holder_drive, holder_enable);
      if (holder_enable) chk(holder_level, regs[a][7]);
   endtask
   task automatic do_write(input int n, input int edges, input int keep);
      int          k;
      logic [14:0] p;
      tx = {};
      for (k = 0; k < n; k++) begin
         p = {7'(rnd() % 80), 8'(rnd())};
         tx.push_back({p[14:8], 1'b0});
         tx.push_back(p[7:0]);
         if (k < keep) wexp.push_back(p);
      end
      in_wr = 1'b1;
      host.frame(tx, edges, rx);
      in_wr = 1'b0;
   endtask
   task automatic chk_writes();
      int k;
      repeat (40) @(posedge ref_clk);
      #1;
      chk(wseen.size(), wexp.size());
      for (k = 0; k < wexp.size() && k < wseen.size(); k++) begin
         chk(wseen[k], wexp[k]);
      end
      wseen = {};
      wexp = {};
   endtask
   task automatic fill(input int n);
      int          k;
      logic [31:0] r;
      for (k = 0; k < n; k++) begin
         r = rnd();
         fq.push_back({r[31:20], MEAS_X, 2'(k % 3), r[15:4], MEAS_Y, 2'(k % 3)});
      end
   endtask
   task automatic fifo_read(input int edges, input int mk);
      logic [31:0] e [$];
      int          k, m0;
      e = fq;
      e.push_back(32'h0003_0007);
      m0 = marks;
      tx = {};
      tx.push_back({FIFO_ADDR, MODE_READ});
      host.frame(tx, edges, rx);
      chk(marks - m0, mk);
      for (k = 0; k < rx.size(); k++) begin
         chk(rx[k], e[k / 4][31 - 8 * (k % 4) -: 8]);
      end
   endtask
   task automatic conv(input logic [7:0] cmd, input logic busy, input int n);
      int c0;
      conv_busy = busy;
      c0 = convs;
      tx = {};
      tx.push_back(cmd);
      host.frame(tx, 8, rx);
      repeat (20) @(posedge ref_clk);
      #1;
      chk(convs - c0, n);
      conv_busy = 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      seed = 32'h0000_003d;
      {holder_enable, wr_drop_clear, conv_busy, in_wr, wr_ready, fifo_avail} = 6'h00;
      rdy_free = 1'b1;
      fifo_block = 32'h0000_0000;
      for (int i = 0; i < 128; i++) regs[i] = 8'(rnd());
      repeat (3) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      do_read(X_RESULT_HIGH_ADDR, 12);
      do_read(7'h05, 3);
      do_read(AUX_RESULT_LOW_ADDR, 2);
      do_write(3, 48, 3);
      chk_writes();
      rdy_free = 1'b0;
      do_write(3, 48, 2);
      chk(wr_drop, 1'b1);
      rdy_free = 1'b1;
      chk_writes();
      wr_drop_clear = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      wr_drop_clear = 1'b0;
      chk(wr_drop, 1'b0);
      do_write(1, 12, 0);
      do_write(2, 32, 2);
      chk_writes();
      chk(oe_wr, 0);
      fill(2);
      fifo_read(104, 2);
      fill(3);
      fifo_read(41, 1);
      fifo_read(42, 2);
      conv(8'he0, 1'b0, 1);
      chk(conv_cmd, 7'h70);
      conv(8'he5, 1'b1, 0);
      tally_and_finish();
   end
endmodule
